// [bstp_pkg.sv]
/*
 * Package for the boundary-scan test port: instruction codes, register
 * lengths, identification field layout, controller states and carriers.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package bstp_pkg;
    // =========================================================
    // Register lengths
    localparam int IR_LEN      = 10;
    localparam int USER_LEN    = 32;
    localparam int USER_FREE   = 7;
    localparam int ID_LEN      = 32;
    localparam int BSR_LEN_DEF = 438;
    // =========================================================
    // Instruction encodings; all ones selects the bypass stage
    localparam logic [9:0] INS_EXTEST   = 10'h000;
    localparam logic [9:0] INS_SAMPLE   = 10'h055;
    localparam logic [9:0] INS_IDCODE   = 10'h059;
    localparam logic [9:0] INS_USERCODE = 10'h007;
    localparam logic [9:0] INS_CFG_LOAD = 10'h002;
    localparam logic [9:0] INS_CFG_DONE = 10'h003;
    localparam logic [9:0] INS_BYPASS   = 10'h3FF;
    // Fixed capture pattern of the instruction register
    localparam logic [9:0] IR_CAPTURE   = 10'h001;
    // =========================================================
    // Identification word fields (arbitrary neutral values)
    localparam logic [3:0]  ID_VERSION  = 4'h3;
    localparam logic [15:0] ID_PART     = 16'hA5C3;
    localparam logic [10:0] ID_MAKER    = 11'h2B4;
    localparam logic        ID_LSB      = 1'h1;
    // Fixed upper 25 bits of the user signature (arbitrary)
    localparam logic [24:0] USER_FIXED  = 25'h0ABCDEF;
    // =========================================================
    // Input synchroniser depth and power-up quiet count
    localparam int SYNC_STAGES  = 2;
    localparam int PWRUP_NS     = 1000;
    localparam int CLK_NS       = 25;
    localparam int PWRUP_CYC    = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
    // =========================================================
    // Controller states
    typedef enum logic [3:0] {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR,
        ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } bstp_state_type;
    // Test pins as sampled in the system clock domain
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bstp_pins_type;
    // Configuration word handed to the loader
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } bstp_cfg_type;
endpackage
`default_nettype wire

// [bstp_fifo.sv]
/*
 * Small valid/ready FIFO for configuration bytes.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module bstp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;
    // Full when pointers differ only in the wrap bit.
    assign in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    // Pointer and storage update.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr[AW-1:0]] <= in_data_i;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule
`default_nettype wire

// [bstp_port.sv]
/*
 * Boundary-scan test access port: sixteen-state controller, instruction
 * register, bypass, identification, user signature, boundary register and
 * configuration byte path into a FIFO.
 * Assumes the test pins arrive asynchronously and are oversampled by clk_i,
 * which must run well above twice the test clock rate.
 */
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Sample/preload captures pin levels into the boundary register while user logic runs, and holds a shifted pattern for later driving.
// - External test drives the boundary pattern onto output pins and captures input pin levels.
// - Bypass puts one stage between serial in and serial out.
// - The user signature instruction shifts the user signature out.
// - The identification instruction shifts the identification word out.
// - Configuration instructions let the host load configuration bytes over the test pins.
// - The instruction register is ten stages long.
// - The user signature is 32 bits, seven from the user design and twenty-five fixed.
// - The boundary register length is set per family member.
// - The identification word is version, part number, maker code and one final bit, msb first.
// - The lowest bit of the identification word is always one.
// - An open-drain pin pulls low when active and floats otherwise.
// - All outputs stay undriven during power-up.
module bstp_port
    import bstp_pkg::*;
#(
    parameter int NPINS   = 8,
    parameter int BSR_LEN = BSR_LEN_DEF
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    // Test pins
    input  wire logic             tck_i,
    input  wire logic             tms_i,
    input  wire logic             tdi_i,
    output logic                  tdo_o,
    output logic                  tdo_oe_n_o,
    // User design side
    input  wire logic [USER_FREE-1:0] user_sig_i,
    input  wire logic [NPINS-1:0] core_out_i,
    input  wire logic [NPINS-1:0] core_oe_i,
    input  wire logic [NPINS-1:0] od_mode_i,
    // Device pins
    input  wire logic [NPINS-1:0] pin_i,
    output logic      [NPINS-1:0] pin_o,
    output logic      [NPINS-1:0] pin_oe_n_o,
    // Configuration byte stream
    output logic                  cfg_valid_o,
    input  wire logic             cfg_ready_i,
    output bstp_cfg_type          cfg_data_o,
    output logic                  cfg_active_o
);
    // =========================================================
    // Input synchronisers
    logic [SYNC_STAGES-1:0] sync_tck, sync_tms, sync_tdi;
    logic [NPINS-1:0]       pin_m, pin_s;
    bstp_pins_type          pins;
    logic                   tck_prev;
    // Two flops per async input; only the second stage is read.
    always_ff @(posedge clk_i)
    begin
        sync_tck <= {sync_tck[0], tck_i};
        sync_tms <= {sync_tms[0], tms_i};
        sync_tdi <= {sync_tdi[0], tdi_i};
        pin_m    <= pin_i;
        pin_s    <= pin_m;
        tck_prev <= pins.tck;
    end
    assign pins = '{tck: sync_tck[1], tms: sync_tms[1], tdi: sync_tdi[1]};
    wire tck_rise = pins.tck && !tck_prev;
    wire tck_fall = !pins.tck && tck_prev;
    // =========================================================
    // Power-up quiet period
    logic [$clog2(PWRUP_CYC+1)-1:0] pwr_cnt;
    wire  powered = (pwr_cnt == PWRUP_CYC[$clog2(PWRUP_CYC+1)-1:0]);
    // Counts the quiet time after reset before any output drives.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            pwr_cnt <= '0;
        else if (!powered)
            pwr_cnt <= pwr_cnt + 1'b1;
    end
    // =========================================================
    // Controller
    bstp_state_type state, next_state;
    logic [2:0]     tms_ones;
    // Standard next-state table of the test access controller.
    always_comb
    begin
        unique case (state)
            ST_RESET:  next_state = pins.tms ? ST_RESET  : ST_IDLE;
            ST_IDLE:   next_state = pins.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: next_state = pins.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = pins.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  next_state = pins.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = pins.tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: next_state = pins.tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: next_state = pins.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = pins.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: next_state = pins.tms ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: next_state = pins.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  next_state = pins.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = pins.tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: next_state = pins.tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: next_state = pins.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = pins.tms ? ST_SEL_DR : ST_IDLE;
        endcase
    end
    // State steps on each sampled rising test clock edge.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state    <= ST_RESET;
            tms_ones <= '0;
        end
        else if (tck_rise)
        begin
            state    <= next_state;
            tms_ones <= pins.tms ? ((tms_ones == 3'h5) ? tms_ones : tms_ones + 3'h1) : 3'h0;
        end
    end
    // =========================================================
    // Instruction register and decode
    logic [IR_LEN-1:0] ir_sh, ir;
    wire sel_byp  = (ir == INS_BYPASS) || !(ir == INS_EXTEST || ir == INS_SAMPLE ||
                    ir == INS_IDCODE || ir == INS_USERCODE || ir == INS_CFG_LOAD ||
                    ir == INS_CFG_DONE);
    wire sel_bsr  = (ir == INS_EXTEST) || (ir == INS_SAMPLE);
    wire sel_id   = (ir == INS_IDCODE);
    wire sel_user = (ir == INS_USERCODE);
    wire sel_cfg  = (ir == INS_CFG_LOAD);
    // Ten-stage shift, updated on leaving update; reset selects the id word.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ir_sh <= IR_CAPTURE;
            ir    <= INS_IDCODE;
        end
        else if (tck_rise)
        begin
            if (state == ST_RESET)
                ir <= INS_IDCODE;
            else if (state == ST_CAP_IR)
                ir_sh <= IR_CAPTURE;
            else if (state == ST_SH_IR)
                ir_sh <= {pins.tdi, ir_sh[IR_LEN-1:1]};
            else if (state == ST_UPD_IR)
                ir <= ir_sh;
        end
    end
    // =========================================================
    // Data registers
    localparam logic [ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
    logic [ID_LEN-1:0]   dr32;
    logic                byp;
    logic [BSR_LEN-1:0]  bsr_sh, bsr_upd;
    logic [7:0]          cfg_sh;
    logic [2:0]          cfg_bits;
    logic                cfg_push;
    wire                 cfg_ready;
    wire [USER_LEN-1:0]  user_word = {USER_FIXED, user_sig_i};
    // Capture value of the boundary cells: pins then output drives.
    wire [BSR_LEN-1:0]   bsr_cap;
    genvar g;
    generate
        for (g = 0; g < BSR_LEN; g++)
        begin : g_cap
            if (g < NPINS)
                assign bsr_cap[g] = pin_s[g];
            else if (g < 2*NPINS)
                assign bsr_cap[g] = core_out_i[g-NPINS];
            else
                assign bsr_cap[g] = bsr_sh[g];
        end
    endgenerate
    // Capture, shift and update of the selected data register.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            dr32     <= '0;
            byp      <= 1'b0;
            bsr_sh   <= '0;
            bsr_upd  <= '0;
            cfg_sh   <= '0;
            cfg_bits <= '0;
            cfg_push <= 1'b0;
        end
        else
        begin
            if (cfg_push && cfg_ready)
                cfg_push <= 1'b0;
            if (tck_rise && state == ST_CAP_DR)
            begin
                byp  <= 1'b0;
                dr32 <= sel_id ? ID_WORD : user_word;
                if (sel_bsr)
                    bsr_sh <= bsr_cap;
                cfg_bits <= '0;
            end
            else if (tck_rise && state == ST_SH_DR)
            begin
                byp    <= pins.tdi;
                dr32   <= {pins.tdi, dr32[ID_LEN-1:1]};
                if (sel_bsr)
                    bsr_sh <= {pins.tdi, bsr_sh[BSR_LEN-1:1]};
                if (sel_cfg && cfg_ready)
                begin
                    cfg_sh   <= {pins.tdi, cfg_sh[7:1]};
                    cfg_bits <= cfg_bits + 3'h1;
                    cfg_push <= (cfg_bits == 3'h7);
                end
            end
            else if (tck_rise && state == ST_UPD_DR && sel_bsr)
                bsr_upd <= bsr_sh;
        end
    end
    // Configuration bytes queue toward the loader.
    bstp_fifo #(.WIDTH(9), .DEPTH(8)) u_fifo (
        .clk_i      (clk_i),
        .sys_rst_i  (sys_rst_i),
        .in_valid_i (cfg_push),
        .in_ready_o (cfg_ready),
        .in_data_i  ({1'b0, cfg_sh}),
        .out_valid_o(cfg_valid_o),
        .out_ready_i(cfg_ready_i),
        .out_data_o (cfg_data_o)
    );
    assign cfg_active_o = sel_cfg || (ir == INS_CFG_DONE);
    // =========================================================
    // Serial output on the falling test clock
    wire serial_bit = sel_byp  ? byp :
                      sel_bsr  ? bsr_sh[0] :
                      sel_cfg  ? 1'b0 : dr32[0];
    wire shifting   = (state == ST_SH_DR) || (state == ST_SH_IR);
    // Output changes only on the falling edge; the host reads it just before the next falling edge.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tdo_o      <= 1'b0;
            tdo_oe_n_o <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_o      <= (state == ST_SH_IR) ? ir_sh[0] : serial_bit;
            tdo_oe_n_o <= !(shifting && powered);
        end
    end
    // =========================================================
    // Pin drivers: external test takes the held pattern.
    wire           extest = (ir == INS_EXTEST);
    wire [NPINS-1:0] drv_val = extest ? bsr_upd[2*NPINS-1:NPINS] : core_out_i;
    wire [NPINS-1:0] drv_en  = extest ? {NPINS{1'b1}} : core_oe_i;
    // Open-drain pins only ever pull low; nothing drives before power-up.
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pin_o      <= '0;
            pin_oe_n_o <= '1;
        end
        else
        begin
            pin_o      <= drv_val & ~od_mode_i;
            pin_oe_n_o <= ~(drv_en & ~(od_mode_i & drv_val)) | {NPINS{!powered}};
        end
    end
    // =========================================================
    // Assertions
    property p_five_high;
        @(posedge clk_i) disable iff (sys_rst_i)
        (tms_ones == 3'h5) |-> (state == ST_RESET);
    endproperty
    a_five_high: assert property (p_five_high) else $error("five highs not in reset");
    property p_reset_id;
        @(posedge clk_i) disable iff (sys_rst_i)
        (state == ST_RESET && tck_rise) |=> (ir == INS_IDCODE);
    endproperty
    a_reset_id: assert property (p_reset_id) else $error("reset lost id select");
    property p_od_never_high;
        @(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |=> ((pin_o & ~pin_oe_n_o & $past(od_mode_i)) == '0);
    endproperty
    a_od_never_high: assert property (p_od_never_high) else $error("open drain high");
    property p_quiet;
        @(posedge clk_i) disable iff (sys_rst_i)
        !powered |-> (pin_oe_n_o == '1) && tdo_oe_n_o;
    endproperty
    a_quiet: assert property (p_quiet) else $error("output driven in power-up");
    property p_id_lsb;
        @(posedge clk_i) disable iff (sys_rst_i)
        (tck_rise && state == ST_CAP_DR && sel_id) |=> (dr32[0] == 1'b1);
    endproperty
    a_id_lsb: assert property (p_id_lsb) else $error("id lsb not one");
    property p_bypass;
        @(posedge clk_i) disable iff (sys_rst_i)
        (tck_rise && state == ST_SH_DR && sel_byp) |=> (byp == $past(pins.tdi));
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass stage wrong");
    property p_user;
        @(posedge clk_i) disable iff (sys_rst_i)
        (tck_rise && state == ST_CAP_DR && sel_user)
            |=> (dr32[USER_FREE-1:0] == $past(user_sig_i));
    endproperty
    a_user: assert property (p_user) else $error("user signature wrong");
    property p_ir_upd;
        @(posedge clk_i) disable iff (sys_rst_i)
        (tck_rise && state == ST_UPD_IR) |=> (ir == $past(ir_sh));
    endproperty
    a_ir_upd: assert property (p_ir_upd) else $error("instruction not updated");
    property p_extest;
        @(posedge clk_i) disable iff (sys_rst_i)
        (extest && powered && od_mode_i == '0) |=> (pin_o == $past(bsr_upd[2*NPINS-1:NPINS]));
    endproperty
    a_extest: assert property (p_extest) else $error("extest pattern not driven");
    c_idcode: cover property (@(posedge clk_i) state == ST_SH_DR && sel_id);
    c_extest: cover property (@(posedge clk_i) extest && powered);
    c_cfg:    cover property (@(posedge clk_i) cfg_valid_o && cfg_ready_i);
endmodule
`default_nettype wire

// [bstp_host.sv]
/*
 * Host model for the boundary-scan test port: drives the test clock, mode
 * select and serial input lines and reads the serial output.
 * Assumes a 200 ns test clock that stays low between transfers.
 */
`timescale 1ns/10ps
`default_nettype none
module bstp_host (
    // Test pins
    output var logic tck_o,
    output var logic tms_o,
    output var logic tdi_o,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_n_i
);
    // =========================================================
    // A released serial output reads high through the pin's weak pull-up.
    wire logic tdo_line = tdo_oe_n_i ? 1'b1 : tdo_i;

    // The lines start idle, with the test clock low.
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end

    // One test clock cycle; the output is read just before the falling edge.
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        tms_o = tms;
        tdi_o = tdi;
        #100 tck_o = 1'b1;
        #95 tdo = tdo_line;
        #5 tck_o = 1'b0;
    endtask

    // Five high mode samples reach reset, one low sample moves on to idle.
    task automatic reset_tap();
        logic d;
        repeat (5) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask

    // Walks from idle to a shift state, shifts n bits lsb first, back to idle.
    task automatic shift(input logic ir, input int n, input logic [447:0] din,
                         output logic [447:0] dout);
        logic d;
        dout = '0;
        step(1'b1, 1'b0, d);
        if (ir)
            step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
        step(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], d);
            dout[i] = d;
        end
        step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask
endmodule
`default_nettype wire

// [bstp_port_bench.sv]
/*
 * Self-checking testbench for the boundary-scan test port.
 * Assumes the host model drives the test pins and the bench all else.
 */
`timescale 1ns/10ps
`default_nettype none
module bstp_port_bench
    import bstp_pkg::*;
;
    // =========================================================
    // Signals
    localparam int BSR = BSR_LEN_DEF;
    logic         clk_i;
    logic         sys_rst_i;
    logic         cfg_ready_i;
    logic [6:0]   user_sig_i;
    logic [3:0]   core_out_i;
    logic [3:0]   core_oe_i;
    logic [3:0]   od_mode_i;
    logic [3:0]   pin_i;
    wire logic    tck;
    wire logic    tms;
    wire logic    tdi;
    wire logic    tdo;
    wire logic    tdo_oe_n;
    wire logic    cfg_valid_o;
    wire logic    cfg_active_o;
    wire logic [3:0] pin_o;
    wire logic [3:0] pin_oe_n_o;
    bstp_cfg_type cfg_data_o;
    logic [447:0] so;
    int           err_count;
    int           n_checks;

    // =========================================================
    // Design and host model
    bstp_port #(.NPINS(4), .BSR_LEN(BSR)) i_bstp_port (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .user_sig_i(user_sig_i),
        .core_out_i(core_out_i), .core_oe_i(core_oe_i), .od_mode_i(od_mode_i),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
        .cfg_valid_o(cfg_valid_o), .cfg_ready_i(cfg_ready_i),
        .cfg_data_o(cfg_data_o), .cfg_active_o(cfg_active_o));
    bstp_host i_bstp_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
        .tdo_oe_n_i(tdo_oe_n));

    // =========================================================
    // Shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic ir(input logic [9:0] code);
        i_bstp_host.shift(1'b1, 10, {438'h0, code}, so);
        check(so[9:0], IR_CAPTURE);
    endtask

    task automatic dr(input int n, input logic [447:0] din);
        i_bstp_host.shift(1'b0, n, din, so);
    endtask

    // =========================================================
    // Scenarios
    task automatic t_powerup();
        repeat (PWRUP_CYC - 2)
        begin
            check({tdo_oe_n, pin_oe_n_o}, 5'h1F);
            cyc(1);
        end
    endtask

    task automatic t_opendrain();
        cyc(8);
        check(pin_oe_n_o, 4'h1);
        check(pin_o & 4'hE, 4'h4);
    endtask

    task automatic t_user();
        ir(INS_USERCODE);
        dr(32, '0);
        check(so[31:0], {USER_FIXED, user_sig_i});
    endtask

    task automatic t_idcode();
        i_bstp_host.reset_tap();
        dr(32, '0);
        check(so[31:0], {ID_VERSION, ID_PART, ID_MAKER, ID_LSB});
        check(so[0], 1'b1);
    endtask

    task automatic t_bypass();
        for (int k = 0; k < 2; k++)
        begin
            ir(k == 0 ? INS_BYPASS : 10'h2AA);
            dr(9, {439'h0, 9'h1A5});
            check(so[8:0], {8'hA5, 1'b0});
        end
    endtask

    task automatic t_sample();
        od_mode_i = 4'h0;
        pin_i = 4'hA;
        ir(INS_SAMPLE);
        dr(BSR + 8, {432'h0, 4'h9, 4'h0, 8'hC3});
        check(so[3:0], 4'hA);
        check(so[BSR+7 -: 8], 8'hC3);
        check({pin_oe_n_o, pin_o}, {4'h0, core_out_i});
    endtask

    task automatic t_extest();
        ir(INS_EXTEST);
        check(pin_o, 4'h9);
        pin_i = 4'h6;
        dr(BSR, {440'h0, 4'h3, 4'h0});
        check(so[3:0], 4'h6);
        cyc(2);
        check(pin_o, 4'h3);
    endtask

    // Configuration comes after the boundary tests, never among them.
    task automatic t_cfg();
        int t;
        ir(INS_CFG_LOAD);
        check(cfg_active_o, 1'b1);
        dr(72, {376'h0, 72'h090807060504030201});
        for (int k = 1; k <= 8; k++)
        begin
            t = 0;
            while (cfg_valid_o !== 1'b1 && t < 100)
            begin
                cyc(1);
                t++;
            end
            if (t == 100)
            begin
                err_count++;
                final_report();
            end
            check(cfg_data_o, {1'b0, 8'(k)});
            cfg_ready_i = 1'b1;
            cyc(1);
            cfg_ready_i = 1'b0;
            cyc(1);
        end
        check(cfg_valid_o, 1'b0);
        ir(INS_CFG_DONE);
        ir(INS_BYPASS);
        check(cfg_active_o, 1'b0);
    endtask

    // =========================================================
    // Clock and main sequence
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial
    begin
        err_count = 0;
        n_checks = 0;
        sys_rst_i = 1'b1;
        cfg_ready_i = 1'b0;
        user_sig_i = 7'h5A;
        core_out_i = 4'h5;
        core_oe_i = 4'hF;
        od_mode_i = 4'h3;
        pin_i = 4'h0;
        repeat (12) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        t_powerup();
        t_opendrain();
        i_bstp_host.reset_tap();
        t_user();
        t_idcode();
        t_bypass();
        t_sample();
        t_extest();
        t_cfg();
        final_report();
    end
endmodule
`default_nettype wire
